// ---- inc/wct_pkg.sv ----
// Constants, register map and helpers of the weekly cam timer.
// Assumes one clock at 250 MHz and an APB register port.
package wct_pkg;
    localparam int NUM_CAMS = 3;
    localparam int NUM_DAYS = 7;
    localparam int TIME_W = 11;
    localparam logic [10:0] TIME_UNSET = 11'h7FF;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [5:0] MIN_MAX = 6'h3B;
    localparam logic [2:0] WD_LAST = 3'h6;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_NOW = 8'h08;
    localparam logic [7:0] OFF_CAM_BASE = 8'h10;
    localparam logic [7:0] OFF_CAM_END = 8'h40;
    localparam logic [3:0] CAM_DAYS = 4'h0;
    localparam logic [3:0] CAM_ON = 4'h4;
    localparam logic [3:0] CAM_OFF = 4'h8;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_PULSE_BIT = 1;
    localparam logic CTRL_EN_RST = 1'b0;
    localparam logic CTRL_PULSE_RST = 1'b0;
    localparam logic [6:0] DAYS_RST = 7'h00;
    localparam int CLK_PERIOD_NS = 4;
    localparam int CYCLE_NS = 1000;
    localparam int CYCLE_CLKS = CYCLE_NS / CLK_PERIOD_NS;

    function automatic logic time_hit(logic [10:0] t, logic [4:0] hr, logic [5:0] mn);
        return (t != TIME_UNSET) && (t == {hr, mn}) && (hr <= HOUR_MAX) && (mn <= MIN_MAX);
    endfunction

    function automatic logic day_hit(logic [6:0] mask, logic [2:0] wd);
        return (wd <= WD_LAST) && mask[wd];
    endfunction
endpackage

// ---- hw/wct_cam.sv ----
// One cam slot: weekday mask and on/off time matched against now.
// Assumes time inputs are stable, same-clock values.
`timescale 1ns/10ps
module wct_cam (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [6:0] days,
    input wire logic [10:0] on_time,
    input wire logic [10:0] off_time,
    input wire logic [2:0] weekday,
    input wire logic [4:0] hour,
    input wire logic [5:0] minute,
    output logic on_hit,
    output logic off_hit
);
    logic day_ok;

    assign day_ok = wct_pkg::day_hit(days, weekday); // RULE8
    assign on_hit = day_ok && wct_pkg::time_hit(on_time, hour, minute); // RULE2
    assign off_hit = day_ok && wct_pkg::time_hit(off_time, hour, minute); // RULE3

    AST_CAM_UNSET: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
        (on_time == wct_pkg::TIME_UNSET) |-> !on_hit)
        else $error("Unset on-time produced a hit");
    AST_CAM_RANGE: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
        (on_hit || off_hit) |-> (hour <= wct_pkg::HOUR_MAX && minute <= wct_pkg::MIN_MAX))
        else $error("Hit outside valid time of day");
endmodule

// ---- hw/wct_cycle.sv ----
// Program cycle tick: one pulse every CYCLE_CLKS clocks.
// Assumes free-running pclk.
`timescale 1ns/10ps
module wct_cycle #(
    parameter int CYCLE_CLKS = wct_pkg::CYCLE_CLKS
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } wct_cyc_state_t;

    wct_cyc_state_t s;
    wct_cyc_state_t next_s;

    if (CYCLE_CLKS < 2 || CYCLE_CLKS > 65536) begin : g_bad
        $error("CYCLE_CLKS out of range");
    end

    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (s.cnt == 16'(CYCLE_CLKS - 1)) begin
            next_s.cnt = 16'h0000;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

    AST_CYC_SPACING: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        tick |=> !tick)
        else $error("Cycle ticks back to back");
endmodule

// ---- hw/wct_timer.sv ----
// Weekly cam timer top: APB registers, three cams, switching output.
// Assumes RTC weekday/hour/minute come from logic on pclk.
// How it works
// RULE1: Three cam slots, each with day mask, on-time and off-time.
// RULE2: On-time hit on a selected day sets the output.
// RULE3: Configured off-time hit on a selected day clears the output.
// RULE4: Pulse option holds the output high one evaluation cycle only.
// RULE5: One pulse setting serves all three cams.
// RULE6: On equal times, cam three beats two, two beats one.
// RULE7: Output follows the combined switching of all cams.
// RULE8: Any weekday subset is allowed; unselected days never switch.
// RULE9: Day mask bit 0 is Monday up to bit 6 Sunday.
// RULE10: Times run 00:00 to 23:59 in hours and minutes.
// RULE11: An unset time code causes no switching.
// RULE12: Each program cycle samples the clock and evaluates at once.
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module wct_timer #(
    parameter int CYCLE_CLKS = wct_pkg::CYCLE_CLKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] rtc_weekday,
    input wire logic [4:0] rtc_hour,
    input wire logic [5:0] rtc_minute,
    output logic switch_out
);
    typedef struct packed {
        logic en;
        logic pulse;
        logic [2:0][6:0] days;
        logic [2:0][10:0] on_t;
        logic [2:0][10:0] off_t;
        logic q;
        logic [2:0] cam_st;
        logic [2:0] wd;
        logic [4:0] hr;
        logic [5:0] mn;
        logic seen;
        logic [31:0] rdata;
        logic err;
    } wct_state_t;

    wct_state_t s;
    wct_state_t next_s;
    logic tick;
    logic [2:0] on_hit;
    logic [2:0] off_hit;
    logic new_min;
    logic act_valid;
    logic act_on;
    logic setup;
    logic wr;
    logic [1:0] ci;

    if (CYCLE_CLKS < 2 || CYCLE_CLKS > 65536) begin : g_bad_cycle
        $error("CYCLE_CLKS out of range");
    end

    if (wct_pkg::NUM_CAMS != 3 || wct_pkg::NUM_DAYS != 7) begin : g_bad_map
        $error("Cam and day counts must match the register map");
    end

    function automatic logic is_cam(logic [7:0] a);
        return (a >= wct_pkg::OFF_CAM_BASE) && (a < wct_pkg::OFF_CAM_END)
            && (a[3:0] == wct_pkg::CAM_DAYS || a[3:0] == wct_pkg::CAM_ON
            || a[3:0] == wct_pkg::CAM_OFF);
    endfunction

    function automatic logic [1:0] cam_of(logic [7:0] a);
        return a[5:4] - 2'h1;
    endfunction

    wct_cycle #(.CYCLE_CLKS(CYCLE_CLKS)) u_wct_cycle (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    for (genvar g = 0; g < wct_pkg::NUM_CAMS; g++) begin : g_cam // RULE1
        wct_cam u_wct_cam (
            .pclk(pclk),
            .presetn(presetn),
            .days(s.days[g]),
            .on_time(s.on_t[g]),
            .off_time(s.off_t[g]),
            .weekday(rtc_weekday),
            .hour(rtc_hour),
            .minute(rtc_minute),
            .on_hit(on_hit[g]),
            .off_hit(off_hit[g])
        );
    end

    // First cycle of each new minute only, so a match acts once
    assign new_min = tick && (!s.seen || {rtc_weekday, rtc_hour, rtc_minute} != {s.wd, s.hr, s.mn});

    // Highest cam with an action decides
    always_comb begin
        act_valid = 1'b0;
        act_on = 1'b0;
        for (int i = 0; i < wct_pkg::NUM_CAMS; i++) begin
            if (on_hit[i] || off_hit[i]) begin // RULE6
                act_valid = 1'b1;
                act_on = on_hit[i];
            end
        end
    end

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign ci = cam_of(paddr);

    always_comb begin
        next_s = s;
        // Sample and compare in the same cycle
        if (tick) begin // RULE12
            next_s.wd = rtc_weekday;
            next_s.hr = rtc_hour;
            next_s.mn = rtc_minute;
            next_s.seen = 1'b1;
        end
        if (new_min) begin
            for (int i = 0; i < wct_pkg::NUM_CAMS; i++) begin
                if (on_hit[i]) begin
                    next_s.cam_st[i] = 1'b1;
                end else if (off_hit[i]) begin
                    next_s.cam_st[i] = 1'b0;
                end
            end
        end
        if (!s.en) begin
            next_s.q = 1'b0;
        end else if (s.pulse) begin // RULE5
            if (tick) begin
                next_s.q = new_min && act_valid && act_on; // RULE4
            end
        end else if (new_min && act_valid) begin // RULE7
            next_s.q = act_on; // RULE2 RULE3
        end
        // Read data and error captured in setup phase
        if (setup) begin
            next_s.rdata = 32'h0000_0000;
            next_s.err = 1'b0;
            if (paddr == wct_pkg::OFF_CTRL) begin
                next_s.rdata[wct_pkg::CTRL_EN_BIT] = s.en;
                next_s.rdata[wct_pkg::CTRL_PULSE_BIT] = s.pulse;
            end else if (paddr == wct_pkg::OFF_STATUS) begin
                next_s.rdata[3:0] = {s.cam_st, s.q};
            end else if (paddr == wct_pkg::OFF_NOW) begin
                next_s.rdata[13:0] = {s.wd, s.hr, s.mn};
            end else if (is_cam(paddr)) begin
                case (paddr[3:0])
                    wct_pkg::CAM_DAYS: next_s.rdata[6:0] = s.days[ci];
                    wct_pkg::CAM_ON: next_s.rdata[10:0] = s.on_t[ci];
                    default: next_s.rdata[10:0] = s.off_t[ci];
                endcase
            end else begin
                next_s.err = 1'b1;
            end
        end
        if (wr) begin
            if (paddr == wct_pkg::OFF_CTRL) begin
                next_s.en = pwdata[wct_pkg::CTRL_EN_BIT];
                next_s.pulse = pwdata[wct_pkg::CTRL_PULSE_BIT];
            end else if (is_cam(paddr)) begin
                case (paddr[3:0])
                    wct_pkg::CAM_DAYS: next_s.days[ci] = pwdata[6:0]; // RULE9
                    wct_pkg::CAM_ON: next_s.on_t[ci] = pwdata[10:0]; // RULE10
                    default: next_s.off_t[ci] = pwdata[10:0]; // RULE11
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.en <= wct_pkg::CTRL_EN_RST;
            s.pulse <= wct_pkg::CTRL_PULSE_RST;
            s.days <= {3{wct_pkg::DAYS_RST}};
            s.on_t <= {3{wct_pkg::TIME_UNSET}};
            s.off_t <= {3{wct_pkg::TIME_UNSET}};
        end else begin
            s <= next_s;
        end
    end

    assign pready = 1'b1;
    assign prdata = s.rdata;
    assign pslverr = s.err;
    assign switch_out = s.q;

    sequence seq_on_act;
        new_min && s.en && act_valid && act_on;
    endsequence

    sequence seq_off_act;
        new_min && s.en && act_valid && !act_on;
    endsequence

    sequence seq_ctrl_wr;
        psel && penable && pwrite && paddr == wct_pkg::OFF_CTRL;
    endsequence

    sequence seq_same_min;
        tick && !new_min;
    endsequence

    sequence seq_bad_time;
        rtc_hour > wct_pkg::HOUR_MAX || rtc_minute > wct_pkg::MIN_MAX;
    endsequence

    sequence seq_days_wr;
        wr && paddr == wct_pkg::OFF_CAM_BASE;
    endsequence

    AST_ON_SETS: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        seq_on_act |=> switch_out)
        else $error("On-time did not set output");
    AST_OFF_CLEARS: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        seq_off_act |=> !switch_out)
        else $error("Off-time did not clear output");
    AST_PULSE_ONE: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        seq_on_act ##0 s.pulse |=> switch_out ##1 (switch_out || !$past(s.en)))
        else $error("Pulse dropped early");
    AST_PULSE_END: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        (s.pulse && switch_out && tick && !new_min) |=> !switch_out)
        else $error("Pulse outlived one cycle");
    AST_PRIO: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        (new_min && s.en && !s.pulse && on_hit[2] && off_hit[1]) |=> switch_out)
        else $error("Cam priority not kept");
    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
        (tick && s.en && !s.pulse && on_hit == 3'h0 && off_hit == 3'h0)
        |=> $stable(switch_out))
        else $error("Output moved without a cam action");
    AST_MASK: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        on_hit[0] |-> s.days[0][rtc_weekday])
        else $error("Hit on unselected weekday");
    AST_SAMPLE: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        tick |=> (s.mn == $past(rtc_minute) && s.hr == $past(rtc_hour)))
        else $error("Clock not sampled on tick");
    AST_CTRL_WR: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        seq_ctrl_wr |=> s.pulse == $past(pwdata[wct_pkg::CTRL_PULSE_BIT]))
        else $error("Pulse setting not written");

    AST_RISE_CAUSE: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        $rose(switch_out)
        |-> $past(new_min && s.en && act_valid && act_on))
        else $error("Output rose without an on action");

    AST_FALL_CAUSE: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        $fell(switch_out) && $past(s.en && !s.pulse)
        |-> $past(new_min && act_valid && !act_on))
        else $error("Output fell without an off action");

    AST_RISE_TICK: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        $rose(switch_out)
        |-> $past(tick))
        else $error("Output rose between program cycles");

    AST_PULSE_FALL: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        $fell(switch_out) && $past(s.en && s.pulse)
        |-> $past(tick))
        else $error("Pulse ended between program cycles");

    AST_PULSE_OFF: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        tick && s.en && s.pulse && !(new_min && act_valid && act_on)
        |=> !switch_out)
        else $error("Pulse held past its program cycle");

    AST_SAME_MIN: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        seq_same_min ##0 (s.en && !s.pulse)
        |=> $stable(switch_out))
        else $error("Repeated minute switched again");

    AST_BAD_TIME: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
        seq_bad_time
        |-> (on_hit == 3'h0 && off_hit == 3'h0))
        else $error("Out of range time produced a hit");

    AST_BAD_DAY: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
        rtc_weekday > wct_pkg::WD_LAST
        |-> (on_hit == 3'h0 && off_hit == 3'h0))
        else $error("Invalid weekday produced a hit");

    AST_MASK_MID: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        (on_hit[1] || off_hit[1])
        |-> s.days[1][rtc_weekday])
        else $error("Second cam hit on unselected weekday");

    AST_MASK_TOP: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
        (on_hit[2] || off_hit[2])
        |-> s.days[2][rtc_weekday])
        else $error("Third cam hit on unselected weekday");

    AST_UNSET_ON3: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
        s.on_t[2] == wct_pkg::TIME_UNSET
        |-> !on_hit[2])
        else $error("Unset on-time of third cam produced a hit");

    AST_UNSET_OFF3: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
        s.off_t[2] == wct_pkg::TIME_UNSET
        |-> !off_hit[2])
        else $error("Unset off-time of third cam produced a hit");

    AST_PRIO_MID: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        new_min && s.en && on_hit == 3'h1 && off_hit[2:1] == 2'h1
        |=> !switch_out)
        else $error("Second cam did not beat first cam");

    AST_CAM_ST: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        new_min && on_hit[0]
        |=> s.cam_st[0])
        else $error("Cam state not set by its on-time");

    AST_EN_WR: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        seq_ctrl_wr
        |=> s.en == $past(pwdata[wct_pkg::CTRL_EN_BIT]))
        else $error("Enable setting not written");

    AST_DAYS_WR: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        seq_days_wr
        |=> s.days[0] == $past(pwdata[6:0]))
        else $error("Day mask not written");

    AST_SEEN: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        tick
        |=> s.seen)
        else $error("Sample not marked after tick");

    AST_NOW_RD: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        setup && paddr == wct_pkg::OFF_NOW
        |=> prdata[13:0] == $past({s.wd, s.hr, s.mn}))
        else $error("Sampled time not returned");
endmodule

// ---- dv/wct_rtc_model.sv ----
// Model of the real-time clock that feeds weekday, hour and minute.
// Assumes the bench moves the time between evaluations via set_time.
`timescale 1ns/10ps
module wct_rtc_model (
    input wire logic pclk,
    output logic [2:0] weekday,
    output logic [4:0] hour,
    output logic [5:0] minute
);
    initial begin
        weekday = 3'h0;
        hour = 5'h00;
        minute = 6'h00;
    end

    // New time lands just after a clock edge
    task automatic set_time(input logic [2:0] wd, input logic [4:0] hr, input logic [5:0] mn);
        @(posedge pclk);
        weekday <= wd;
        hour <= hr;
        minute <= mn;
    endtask
endmodule

// ---- dv/wct_timer_tb_top.sv ----
// Self-checking bench of the weekly cam timer over APB.
// Assumes zero-wait APB slave and a short program cycle.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_errors++; \
    $display("MISMATCH %s exp=%h got=%h", nm, ex, got); end end
module wct_timer_tb_top;
    localparam int CYC = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, switch_out;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] rtc_weekday;
    logic [4:0] rtc_hour;
    logic [5:0] rtc_minute;
    logic er;
    int n_errors = 0;
    int n_tests = 0;

    wct_timer #(.CYCLE_CLKS(CYC)) u_wct_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rtc_weekday(rtc_weekday), .rtc_hour(rtc_hour),
        .rtc_minute(rtc_minute), .switch_out(switch_out));
    wct_rtc_model u_wct_rtc_model (.pclk(pclk), .weekday(rtc_weekday), .hour(rtc_hour),
        .minute(rtc_minute));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    function automatic logic [31:0] tm(input int h, input int m);
        return 32'(h * 64 + m);
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cam_cfg(input int n, input logic [31:0] dy, input logic [31:0] on_t,
        input logic [31:0] off_t);
        apb(1'b1, 8'(16 * n), dy);
        apb(1'b1, 8'(16 * n + 4), on_t);
        apb(1'b1, 8'(16 * n + 8), off_t);
    endtask

    task automatic go(input int wd, input int h, input int m);
        u_wct_rtc_model.set_time(3'(wd), 5'(h), 6'(m));
        repeat (2 * CYC + 2) @(posedge pclk);
        #1;
    endtask

    task automatic t_reset;
        apb(1'b0, 8'h00, 32'h0);
        `CHK("ctrl", 32'h0, rd)
        `CHK("ctrl_resp", 1'b0, er)
        `CHK("ready", 1'b1, pready)
        apb(1'b0, 8'h20, 32'h0);
        `CHK("days2", 32'h0, rd)
        apb(1'b0, 8'h38, 32'h0);
        `CHK("off3", 32'h7FF, rd)
        apb(1'b0, 8'h0C, 32'h0);
        `CHK("unmapped", 1'b1, er)
        `CHK("out_rst", 1'b0, switch_out)
    endtask

    task automatic t_onoff;
        apb(1'b1, 8'h00, 32'h1);
        cam_cfg(1, 32'h2, tm(2, 32), tm(23, 59));
        go(2, 2, 32);
        `CHK("wed_on", 1'b0, switch_out)
        go(1, 2, 32);
        `CHK("tue_on", 1'b1, switch_out)
        apb(1'b0, 8'h04, 32'h0);
        `CHK("status", 32'h3, rd)
        apb(1'b0, 8'h08, 32'h0);
        `CHK("now", 32'h08A0, rd)
        go(1, 23, 59);
        `CHK("tue_off", 1'b0, switch_out)
        cam_cfg(1, 32'h7F, tm(24, 0), 32'h7FF);
        go(4, 24, 0);
        `CHK("bad_hour", 1'b0, switch_out)
        apb(1'b1, 8'h14, tm(3, 0));
        go(7, 3, 0);
        `CHK("bad_day", 1'b0, switch_out)
        cam_cfg(1, 32'h7F, 32'h7FF, 32'h7FF);
        go(4, 0, 0);
        `CHK("unset", 1'b0, switch_out)
    endtask

    task automatic t_prio;
        cam_cfg(1, 32'h7F, tm(5, 0), 32'h7FF);
        cam_cfg(2, 32'h7F, 32'h7FF, tm(5, 0));
        go(6, 5, 0);
        `CHK("two_beats_one", 1'b0, switch_out)
        cam_cfg(3, 32'h7F, tm(5, 0), 32'h7FF);
        go(6, 4, 59);
        go(6, 5, 0);
        `CHK("three_beats_two", 1'b1, switch_out)
    endtask

    task automatic t_pulse;
        int i;
        int cnt;
        apb(1'b1, 8'h00, 32'h3);
        for (int n = 1; n <= 3; n++) begin
            for (int k = 1; k <= 3; k++) begin
                cam_cfg(k, (k == n) ? 32'h7F : 32'h0, tm(6, n), 32'h7FF);
            end
            u_wct_rtc_model.set_time(3'h3, 5'h06, 6'(n));
            i = 0;
            while (switch_out !== 1'b1 && i < 4 * CYC) begin
                @(posedge pclk);
                #1;
                i++;
            end
            cnt = 0;
            while (switch_out === 1'b1 && cnt < 8 * CYC) begin
                @(posedge pclk);
                #1;
                cnt++;
            end
            `CHK("pulse_len", CYC, cnt)
            `CHK("pulse_cam", 1'b1, i < 4 * CYC)
        end
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_onoff;
        t_prio;
        t_pulse;
        complete_run;
    end

    initial begin
        #80000;
        n_errors++;
        complete_run;
    end
endmodule
